// *** dv/test_usb_io_power_mgmt_reg.sv ***
module test_usb_io_power_mgmt_reg
  import uiop_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic txen = 1'b0;
  uiop_mode_t mode = UIOP_MODE_USB;
  uiop_req_t req;
  uiop_ctrl_t ctrl;
  logic [7:0] rdata;
  logic rvalid;
  logic hit;
  int bad_count = 0;
  int num_checks = 0;
  // 100 MHz clock
  always #5 mclk = ~mclk;
  uiop_ctrl dut (.mclk(mclk), .rstn(rstn), .ce(ce), .req(req), .rdata(rdata), .rvalid(rvalid),
    .hit(hit), .mode(mode), .uart_transmit_enable(txen), .ctrl(ctrl));
  uiop_link_model link (.mclk(mclk), .req(req), .rdata(rdata), .rvalid(rvalid), .hit(hit));
  //////////////////////////////////////////
  task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s exp %h got %h", what, exp, got);
    end
  endtask
  // Read and compare the hit, the strobe and the byte
  task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp);
    link.access(1'b0, a, 8'h00);
    cmp("hit", 8'h01, {7'h00, link.got_hit});
    cmp("rvalid", 8'h01, {7'h00, link.got_valid});
    cmp("rdata", exp, link.got_data);
  endtask
  // Settle mode inputs, then look at the front-end controls
  task automatic ctl_chk(input uiop_mode_t m, input logic t, input logic [5:0] exp);
    @(posedge mclk);
    #1 mode = m;
    txen = t;
    repeat (3) @(posedge mclk);
    #1 cmp("ctrl", {2'h0, exp}, {2'h0, ctrl});
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  //////////////////////////////////////////
  initial begin
    repeat (20) @(posedge mclk);
    #1 rstn = 1'b1;
    for (int i = 0; i < 3; i++) begin
      rd_chk(6'h39 + 6'(i), 8'h04);
    end
    ctl_chk(UIOP_MODE_USB, 1'b0, 6'h00);
    link.access(1'b1, 6'h39, 8'hFF);
    rd_chk(6'h3B, 8'hFE);
    link.access(1'b1, 6'h3B, 8'hB1);
    rd_chk(6'h39, 8'h4E);
    link.access(1'b1, 6'h3A, 8'h11);
    rd_chk(6'h3A, 8'h5E);
    link.access(1'b1, 6'h3C, 8'hFF);
    cmp("hit", 8'h00, {7'h00, link.got_hit});
    link.access(1'b1, 6'h31, 8'h00);
    cmp("hit", 8'h00, {7'h00, link.got_hit});
    link.access(1'b0, 6'h3C, 8'h00);
    cmp("hit", 8'h00, {7'h00, link.got_hit});
    cmp("rvalid", 8'h00, {7'h00, link.got_valid});
    // Frozen clock enable must drop the write
    ce = 1'b0;
    link.access(1'b1, 6'h39, 8'h00);
    ce = 1'b1;
    rd_chk(6'h39, 8'h5E);
    ctl_chk(UIOP_MODE_USB, 1'b0, 6'h1A);
    ctl_chk(UIOP_MODE_AUDIO, 1'b1, 6'h08);
    ctl_chk(UIOP_MODE_UART, 1'b0, 6'h1F);
    ctl_chk(UIOP_MODE_UART, 1'b1, 6'h3F);
    // UART voltage stays latched after transmit enable drops
    ctl_chk(UIOP_MODE_UART, 1'b0, 6'h3F);
    // Leave UART mode through reset, not through register traffic
    rstn = 1'b0;
    mode = UIOP_MODE_USB;
    txen = 1'b0;
    repeat (2) @(posedge mclk);
    #1 rstn = 1'b1;
    rd_chk(6'h39, 8'h04);
    ctl_chk(UIOP_MODE_USB, 1'b0, 6'h00);
    close_out();
  end
  // Whole run is about 80 cycles; this limit sits at 5000
  initial begin
    #50000;
    bad_count++;
    close_out();
  end
endmodule

// *** dv/uiop_link_model.sv ***
// Link side of the immediate register path
module uiop_link_model
  import uiop_pkg::*;
(
  // Clock
  input wire logic mclk,
  // Request out, answer in
  output uiop_req_t req,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  input wire logic hit
);
  timeunit 1ns;
  timeprecision 100ps;
  // Last answer seen; kept local so the bench reads them with no port delay
  logic [7:0] got_data = 8'h00;
  logic got_valid = 1'b0;
  logic got_hit = 1'b0;
  initial req = '{wr:1'b0, rd:1'b0, addr:6'h00, wdata:8'h00};
  // One access held over one taken edge; on release the strobes drop, address and data show the inverse
  task automatic access(input logic w, input logic [5:0] a, input logic [7:0] d);
    @(posedge mclk);
    #1 req = '{wr:w, rd:~w, addr:a, wdata:d};
    @(posedge mclk);
    // Address match taken at the edge that takes the request
    got_hit = hit;
    #1 req = '{wr:1'b0, rd:1'b0, addr:~a, wdata:~d};
    // Registered answer stands from the taking edge to the next one
    got_valid = rvalid;
    got_data = rdata;
  endtask
endmodule

// *** hw/uiop_ctrl.sv ***
// Operation
// - Reads at 39h, 3Ah, 3Bh return same value
// - 39h writes, 3Ah sets, 3Bh clears
// - Swap bit exchanges DP and DM roles
// - UART swaps routing; audio speaker pins unaffected
// - UART regulator field bits 3:2, reset 01
// - UART voltage applied once transmit enable asserts
// - Audio mode forces regulator to 3.3 V
// - Charger pull-ups bits 4,5; forced in UART
// - USB regulator field bits 7:6, reset 00
// - Access only through immediate reads/writes 39h-3Bh
`include "uiop_regs.svh"
module uiop_ctrl
  import uiop_pkg::*;
(
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  // Immediate register access
  input wire uiop_req_t req,
  output logic [7:0] rdata,
  output logic rvalid,
  output logic hit,
  // Transceiver mode inputs
  input wire uiop_mode_t mode,
  input wire logic uart_transmit_enable,
  // Analog front-end controls
  output uiop_ctrl_t ctrl
);

  ////////////////////////////////////////////////////////////////////////
  // Storage and decode
  uiop_reg_t ctl_reg; // Register contents
  uiop_reg_t ctl_next; // Next register value
  logic is_write; // Write alias hit
  logic is_set; // Set alias hit
  logic is_clear; // Clear alias hit
  logic uart_armed_reg; // UART voltage latched in after transmit enable
  logic [1:0] reg_sel_next; // Regulator code before flop

  // Strip the reserved bit; shared by all three write aliases and the read path
  function automatic logic [7:0] writable(input logic [7:0] val);
    return val & `UIOP_WRITE_MASK;
  endfunction

  // Address decode shared by read and write paths
  uiop_decode u_dec (
    .addr(req.addr),
    .hit(hit),
    .is_write(is_write),
    .is_set(is_set),
    .is_clear(is_clear)
  );

  // Masked write, set and clear; reserved bit never stored
  always_comb begin
    ctl_next = ctl_reg;
    if (req.wr && is_write) begin
      ctl_next = uiop_reg_t'(writable(req.wdata));
    end else if (req.wr && is_set) begin
      ctl_next = uiop_reg_t'(8'(ctl_reg) | writable(req.wdata));
    end else if (req.wr && is_clear) begin
      ctl_next = uiop_reg_t'(8'(ctl_reg) & ~writable(req.wdata));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register update
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      ctl_reg <= uiop_reg_t'(`UIOP_RESET_VAL);
    end else if (ce) begin
      ctl_reg <= ctl_next;
    end
  end

  // Read data, same for every alias; addresses outside decode are not ours
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rdata <= 8'h00;
      rvalid <= 1'b0;
    end else if (ce) begin
      rvalid <= req.rd && hit;
      if (req.rd && hit) begin
        rdata <= writable(8'(ctl_reg));
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // UART regulator hand-over: old USB voltage holds until transmit enable
  // The latch keeps the UART voltage after transmit enable drops again, so a
  // quiet serial line does not bounce the supply back; only leaving UART mode
  // (reset being the preferred way out) hands control back to the USB field
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      uart_armed_reg <= 1'b0;
    end else if (ce) begin
      if (mode != UIOP_MODE_UART) begin
        uart_armed_reg <= 1'b0;
      end else if (uart_transmit_enable) begin
        uart_armed_reg <= 1'b1;
      end
    end
  end

  // Regulator selection by mode
  always_comb begin
    unique case (mode)
      UIOP_MODE_AUDIO: reg_sel_next = `UIOP_VSEL_3V3;
      UIOP_MODE_UART: reg_sel_next = (uart_armed_reg || uart_transmit_enable) ?
        ctl_reg.uart_regulator_voltage_sel : ctl_reg.usb_regulator_voltage_sel;
      default: reg_sel_next = ctl_reg.usb_regulator_voltage_sel;
    endcase
  end

  // Front-end controls from flops
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      ctrl <= '0;
    end else if (ce) begin
      ctrl.regulator_sel <= reg_sel_next;
      ctrl.pullup_plus <= ctl_reg.charger_pullup_en_plus || (mode == UIOP_MODE_UART);
      ctrl.pullup_minus <= ctl_reg.charger_pullup_en_minus || (mode == UIOP_MODE_UART);
      // Swap never reaches the speaker path in audio mode
      ctrl.swap_active <= ctl_reg.data_line_swap && (mode != UIOP_MODE_AUDIO);
      ctrl.uart_swap <= ctl_reg.data_line_swap && (mode == UIOP_MODE_UART);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  reg_reset_val_a: assert property (@(posedge mclk) !rstn |=> 8'(ctl_reg) == `UIOP_RESET_VAL)
    else $error("reset value wrong");

  // Reset clears the read path and the front-end controls as well
  ctrl_reset_a: assert property (@(posedge mclk) !rstn |=> ctrl == '0 && !rvalid && rdata == 8'h00)
    else $error("outputs not cleared by reset");

  // Write aliases: whole value, ones set, ones cleared
  set_only_ones_a: assert property (@(posedge mclk) disable iff (!rstn)
    ce && req.wr && is_set |=> 8'(ctl_reg) == ($past(8'(ctl_reg)) | ($past(req.wdata) & 8'hFE)))
    else $error("set alias wrong");
  clear_only_ones_a: assert property (@(posedge mclk) disable iff (!rstn)
    ce && req.wr && is_clear |=> 8'(ctl_reg) == ($past(8'(ctl_reg)) & ~$past(req.wdata)))
    else $error("clear alias wrong");
  write_alias_a: assert property (@(posedge mclk) disable iff (!rstn)
    ce && req.wr && is_write |=> 8'(ctl_reg) == ($past(req.wdata) & 8'hFE))
    else $error("write alias wrong");

  // Foreign addresses leave the register and the read strobe alone
  foreign_write_a: assert property (@(posedge mclk) disable iff (!rstn)
    ce && req.wr && !hit |=> $stable(8'(ctl_reg)))
    else $error("foreign address changed register");
  foreign_read_a: assert property (@(posedge mclk) disable iff (!rstn)
    ce && req.rd && !hit |=> !rvalid)
    else $error("foreign address answered");

  // Read path: every alias answers with the stored byte
  read_alias_a: assert property (@(posedge mclk) disable iff (!rstn)
    ce && req.rd && hit && !req.wr |=> rvalid && rdata == 8'(ctl_reg))
    else $error("read data mismatch");
  bit0_zero_a: assert property (@(posedge mclk) disable iff (!rstn) !ctl_reg.reserved && !rdata[0])
    else $error("reserved bit set");

  // Enable low holds every flop, read strobe included; reset still wins,
  // so the check stands down while reset is low
  ce_freeze_a: assert property (@(posedge mclk) disable iff (!rstn)
    !ce |=> $stable(8'(ctl_reg)) && $stable(ctrl) && $stable(rdata)
    && $stable(rvalid) && $stable(uart_armed_reg))
    else $error("state moved with enable low");

  // Regulator code by mode and hand-over state; the UART field only
  // takes over once transmit enable has been seen in UART mode
  audio_3v3_a: assert property (@(posedge mclk) disable iff (!rstn)
    ce && mode == UIOP_MODE_AUDIO |=> ctrl.regulator_sel == 2'h0 && !ctrl.swap_active)
    else $error("audio regulator not 3.3V");
  uart_volt_a: assert property (@(posedge mclk) disable iff (!rstn)
    ce && mode == UIOP_MODE_UART && uart_transmit_enable
    |=> ctrl.regulator_sel == $past(ctl_reg.uart_regulator_voltage_sel))
    else $error("uart voltage not applied");
  armed_hold_a: assert property (@(posedge mclk) disable iff (!rstn)
    ce && mode == UIOP_MODE_UART && uart_armed_reg
    |=> ctrl.regulator_sel == $past(ctl_reg.uart_regulator_voltage_sel))
    else $error("latched uart voltage lost");
  uart_wait_a: assert property (@(posedge mclk) disable iff (!rstn)
    ce && mode == UIOP_MODE_UART && !uart_armed_reg && !uart_transmit_enable
    |=> ctrl.regulator_sel == $past(ctl_reg.usb_regulator_voltage_sel))
    else $error("uart voltage applied early");
  usb_volt_a: assert property (@(posedge mclk) disable iff (!rstn)
    ce && mode == UIOP_MODE_USB |=> ctrl.regulator_sel == $past(ctl_reg.usb_regulator_voltage_sel))
    else $error("usb voltage wrong");

  // Pull-ups and data-line swap
  uart_pullup_a: assert property (@(posedge mclk) disable iff (!rstn)
    ce && mode == UIOP_MODE_UART |=> ctrl.pullup_plus && ctrl.pullup_minus)
    else $error("uart pullups off");
  pullup_bits_a: assert property (@(posedge mclk) disable iff (!rstn)
    ce && mode != UIOP_MODE_UART
    |=> ctrl.pullup_plus == $past(ctl_reg.charger_pullup_en_plus)
    && ctrl.pullup_minus == $past(ctl_reg.charger_pullup_en_minus))
    else $error("pullup does not follow bit");
  swap_usb_a: assert property (@(posedge mclk) disable iff (!rstn)
    ce && mode == UIOP_MODE_USB |=> ctrl.swap_active == $past(ctl_reg.data_line_swap))
    else $error("swap not applied");
  uart_swap_a: assert property (@(posedge mclk) disable iff (!rstn)
    ce && mode == UIOP_MODE_UART |=> ctrl.uart_swap == $past(ctl_reg.data_line_swap))
    else $error("uart swap wrong");
  audio_speaker_a: assert property (@(posedge mclk) disable iff (!rstn)
    ce && mode == UIOP_MODE_AUDIO |=> !ctrl.uart_swap)
    else $error("swap reached speaker path");

  // Main scenarios
  cov_set_c: cover property (@(posedge mclk) ce && req.wr && is_set);
  cov_clear_c: cover property (@(posedge mclk) ce && req.wr && is_clear);
  cov_read_c: cover property (@(posedge mclk) ce && req.rd && hit);
  cov_uart_c: cover property (@(posedge mclk) mode == UIOP_MODE_UART ##1 uart_transmit_enable);
  cov_audio_c: cover property (@(posedge mclk) mode == UIOP_MODE_AUDIO);
endmodule

// *** hw/uiop_decode.sv ***
`include "uiop_regs.svh"
// Address decoder for the aliased write/set/clear register
module uiop_decode
  import uiop_pkg::*;
(
  // Address in
  input wire logic [5:0] addr,
  // Decode results
  output logic hit,
  output logic is_write,
  output logic is_set,
  output logic is_clear
);
  // All three aliases read the same content
  always_comb begin
    is_write = (addr == `UIOP_ADDR_WRITE);
    is_set = (addr == `UIOP_ADDR_SET);
    is_clear = (addr == `UIOP_ADDR_CLEAR);
    hit = is_write | is_set | is_clear;
  end
endmodule

// *** hw/uiop_pkg.sv ***
package uiop_pkg;
  // Operating mode of the transceiver
  typedef enum logic [1:0] {
    UIOP_MODE_USB = 2'h0,
    UIOP_MODE_UART = 2'h1,
    UIOP_MODE_AUDIO = 2'h3
  } uiop_mode_t;

  // Register fields as stored
  typedef struct packed {
    logic [1:0] usb_regulator_voltage_sel;
    logic charger_pullup_en_minus;
    logic charger_pullup_en_plus;
    logic [1:0] uart_regulator_voltage_sel;
    logic data_line_swap;
    logic reserved;
  } uiop_reg_t;

  // Immediate register access request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } uiop_req_t;

  // Controls to the analog front end
  typedef struct packed {
    logic [1:0] regulator_sel;
    logic pullup_plus;
    logic pullup_minus;
    logic swap_active;
    logic uart_swap;
  } uiop_ctrl_t;
endpackage

// *** hw/uiop_regs.svh ***
`ifndef UIOP_REGS_SVH
`define UIOP_REGS_SVH
// Register addresses (6-bit ULPI immediate address space)
`define UIOP_ADDR_WRITE 6'h39
`define UIOP_ADDR_SET 6'h3A
`define UIOP_ADDR_CLEAR 6'h3B
`define UIOP_VENDOR_LO 6'h30
`define UIOP_VENDOR_HI 6'h3F
// Field positions
`define UIOP_BIT_SWAP 1
`define UIOP_BIT_UART_LO 2
`define UIOP_BIT_PU_PLUS 4
`define UIOP_BIT_PU_MINUS 5
`define UIOP_BIT_USB_LO 6
// Reset value and writable mask (bit 0 reserved)
`define UIOP_RESET_VAL 8'h04
`define UIOP_WRITE_MASK 8'hFE
// Regulator code for 3.3 V
`define UIOP_VSEL_3V3 2'h0
`endif
